// [cip_pkg.sv]
// constants for the configurable i/o port set: register map, field layout,
// reset values and the tristate refresh timing
// assumes a 50 MHz hclk and a 32-bit ahb-lite register bus
package cip_pkg;
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned CLK_PERIOD_NS = 20;

    // the tristate refresh period, as time and as cycles
    localparam int unsigned REFRESH_NS = 1000;
    localparam int unsigned REFRESH_CYC = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // pin counts
    localparam int unsigned CPORT_W = 8;
    localparam int unsigned FOUT_W = 8;
    localparam int unsigned FIN_W = 8;
    localparam int unsigned SHARED_W = 4;
    localparam int unsigned FAN_W = 3;
    localparam int unsigned SYNC_W = CPORT_W + FIN_W + SHARED_W;

    // register byte addresses
    localparam logic [7:0] DIR_OFF = 8'h00;
    localparam logic [7:0] TRIS_OFF = 8'h04;
    localparam logic [7:0] OUT_OFF = 8'h08;
    localparam logic [7:0] CIN_OFF = 8'h0C;
    localparam logic [7:0] FOUT_OFF = 8'h10;
    localparam logic [7:0] FIN_OFF = 8'h14;
    localparam logic [7:0] SHARED_OFF = 8'h18;
    localparam logic [7:0] CMD_OFF = 8'h1C;
    localparam logic [7:0] FUNC_OFF = 8'h20;
    localparam logic [7:0] HWTRIS_OFF = 8'h24;

    // pin command register fields
    localparam int unsigned CMD_PIN_LSB = 0;
    localparam int unsigned CMD_OP_LSB = 8;
    localparam logic [1:0] OP_LOW = 2'h0;
    localparam logic [1:0] OP_HIGH = 2'h1;
    localparam logic [1:0] OP_OUTPUT = 2'h2;
    localparam logic [1:0] OP_INPUT = 2'h3;

    // function register fields
    localparam int unsigned FUNC_PWM_BIT = 0;
    localparam int unsigned FUNC_I2C_BIT = 1;
    localparam int unsigned FUNC_SHDIG_LSB = 4;

    // special pin positions
    localparam int unsigned PWM1_BIT = 1;
    localparam int unsigned PWM2_BIT = 2;
    localparam int unsigned SCL_BIT = 3;
    localparam int unsigned SDA_BIT = 4;
    localparam int unsigned IR_BIT = 0;
    localparam int unsigned KCLK_BIT = 6;
    localparam int unsigned KDAT_BIT = 7;

    // reset values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [7:0] FOUT_RST = 8'h00;
    localparam logic [7:0] FUNC_RST = 8'h00;
    localparam logic [2:0] FAN_ADC_ON = 3'h7;
endpackage : cip_pkg

// [cip_pin_sync.sv]
// three-stage synchroniser for pins; a bit changes once stages two and three agree
// assumes pins are asynchronous to hclk
`timescale 1ns/1ps
module cip_pin_sync #(
    parameter int unsigned W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] st;
    } cip_sync_type;

    cip_sync_type st_ff;
    cip_sync_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // only the agreeing bits move, so a one-cycle glitch never reaches the output
        nxt_st.st = ((st_ff.s2 ~^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.st);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stable = st_ff.st;
endmodule : cip_pin_sync

// [cip_tick.sv]
// free-running divider that gives a one-cycle enable every PERIOD cycles
// assumes a single hclk domain
`timescale 1ns/1ps
module cip_tick #(
    parameter int unsigned PERIOD = 50
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic pulse;
    } cip_tick_type;

    cip_tick_type st_ff;
    cip_tick_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (st_ff.cnt == 16'(PERIOD - 1)) begin
            nxt_st.cnt = 16'h0000;
            nxt_st.pulse = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.pulse;
endmodule : cip_tick

// [cip_port_set.sv]
// configurable i/o port set: configurable 8-bit port, shared analogue/digital
// port, fixed output, fixed input and fixed analogue ports behind ahb-lite
// assumes single word transfers only; pins are asynchronous to hclk
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - configurable port has eight pins, all inputs after reset, each switchable
// - pin high/low command makes that pin an output and drives the level
// - direction register: one bit per pin, 1 output, 0 input
// - inverted twin of direction: 1 input, 0 output, always consistent
// - hardware tristate periodically refreshed from direction; raw writes get overwritten
// - output register drives each output pin to its bit level, except pins 1,2 while pwm is selected
// - shared port: four pins, analogue by default, readable as digital inputs
// - fixed output port: eight pins, always outputs
// - fixed analogue port: three pins, permanently analogue
// - fixed input port: eight digital inputs, the standard input read
// - configurable port inputs read through their own separate register
// - bits 1,2 pwm outputs, bits 3,4 i2c inputs when selected
// - fixed input bit 0 infrared, bits 6,7 keyboard clock and data
// - shared port reads are plain levels; one read covers one port
module cip_port_set (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] cport_in,
    output logic [7:0] cport_out,
    output logic [7:0] cport_oe,
    input wire logic [1:0] pwm_level,
    input wire logic [7:0] fixed_input_port,
    output logic [7:0] fixed_output_port,
    input wire logic [3:0] shared_in,
    output logic [3:0] shared_adc_en,
    output logic [2:0] fixed_analogue_port_adc_en,
    output logic ir_rx,
    output logic kbd_clk,
    output logic kbd_data,
    output logic i2c_scl,
    output logic i2c_sda
);
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] outl;
        logic [7:0] hw_tris;
        logic [7:0] fout;
        logic [7:0] func;
        logic [31:0] rdata;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
        logic [3:0] sh_adc;
        logic [2:0] fan_adc;
        logic [4:0] spec;
        logic ready;
        logic resp;
    } cip_state_type;

    cip_state_type st_ff;
    cip_state_type nxt_st;

    logic [cip_pkg::SYNC_W-1:0] sync_st;
    logic [7:0] cin_st;
    logic [7:0] fin_st;
    logic [3:0] sh_st;
    logic refresh_tick;
    logic addr_ok;
    logic dp_wr;
    logic [2:0] cmd_pin;
    logic [1:0] cmd_op;

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    cip_pin_sync #(
        .W(cip_pkg::SYNC_W)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in({shared_in, fixed_input_port, cport_in}),
        .stable(sync_st)
    );

    cip_tick #(
        .PERIOD(cip_pkg::REFRESH_CYC)
    ) u_refresh (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(refresh_tick)
    );

    assign cin_st = sync_st[7:0];
    assign fin_st = sync_st[15:8];
    assign sh_st = sync_st[19:16];
    assign addr_ok = hsel && htrans[1] && hready;
    assign dp_wr = st_ff.dp_valid && st_ff.dp_write;
    assign cmd_pin = hwdata[cip_pkg::CMD_PIN_LSB +: 3];
    assign cmd_op = hwdata[cip_pkg::CMD_OP_LSB +: 2];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ready = 1'b1;
        // every transfer ends okay; unmapped offsets are ignored, not refused
        nxt_st.resp = 1'b0;
        // hsize is not decoded, so a narrow write acts as a whole word
        // address phase is captured; writes land in the following data phase
        nxt_st.dp_valid = addr_ok;
        nxt_st.dp_write = hwrite;
        nxt_st.dp_addr = haddr[7:0];

        if (dp_wr) begin
            if (reg_hit(st_ff.dp_addr, cip_pkg::DIR_OFF)) begin
                nxt_st.dir = hwdata[7:0];
            end
            if (reg_hit(st_ff.dp_addr, cip_pkg::TRIS_OFF)) begin
                nxt_st.dir = ~hwdata[7:0];
            end
            if (reg_hit(st_ff.dp_addr, cip_pkg::OUT_OFF)) begin
                nxt_st.outl = hwdata[7:0];
            end
            if (reg_hit(st_ff.dp_addr, cip_pkg::FOUT_OFF)) begin
                nxt_st.fout = hwdata[7:0];
            end
            if (reg_hit(st_ff.dp_addr, cip_pkg::FUNC_OFF)) begin
                nxt_st.func = hwdata[7:0];
            end
            if (reg_hit(st_ff.dp_addr, cip_pkg::CMD_OFF)) begin
                case (cmd_op)
                    cip_pkg::OP_LOW: begin
                        nxt_st.dir[cmd_pin] = 1'b1;
                        nxt_st.outl[cmd_pin] = 1'b0;
                    end
                    cip_pkg::OP_HIGH: begin
                        nxt_st.dir[cmd_pin] = 1'b1;
                        nxt_st.outl[cmd_pin] = 1'b1;
                    end
                    cip_pkg::OP_OUTPUT: begin
                        nxt_st.dir[cmd_pin] = 1'b1;
                    end
                    default: begin
                        nxt_st.dir[cmd_pin] = 1'b0;
                    end
                endcase
            end
        end

        // the refresh copies direction into the live tristate; a raw write only
        // lasts until the next refresh or direction change, as on the real part
        if (refresh_tick || (nxt_st.dir != st_ff.dir)) begin
            nxt_st.hw_tris = ~nxt_st.dir;
        end else if (dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::HWTRIS_OFF)) begin
            nxt_st.hw_tris = hwdata[7:0];
        end

        // pad drive follows the live tristate, then the special functions
        nxt_st.pad_oe = ~nxt_st.hw_tris;
        nxt_st.pad_out = nxt_st.outl;
        if (nxt_st.func[cip_pkg::FUNC_PWM_BIT]) begin
            nxt_st.pad_oe[cip_pkg::PWM1_BIT] = 1'b1;
            nxt_st.pad_oe[cip_pkg::PWM2_BIT] = 1'b1;
            nxt_st.pad_out[cip_pkg::PWM1_BIT] = pwm_level[0];
            nxt_st.pad_out[cip_pkg::PWM2_BIT] = pwm_level[1];
        end
        if (nxt_st.func[cip_pkg::FUNC_I2C_BIT]) begin
            nxt_st.pad_oe[cip_pkg::SCL_BIT] = 1'b0;
            nxt_st.pad_oe[cip_pkg::SDA_BIT] = 1'b0;
        end

        // shared port pins stay on the converter unless switched to digital
        nxt_st.sh_adc = ~nxt_st.func[cip_pkg::FUNC_SHDIG_LSB +: 4];
        nxt_st.fan_adc = cip_pkg::FAN_ADC_ON;
        nxt_st.spec = {cin_st[cip_pkg::SDA_BIT], cin_st[cip_pkg::SCL_BIT],
                       fin_st[cip_pkg::KDAT_BIT], fin_st[cip_pkg::KCLK_BIT],
                       fin_st[cip_pkg::IR_BIT]};

        // read data is built from the next state so a write followed straight
        // by a read of the same register returns the new value
        nxt_st.rdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                cip_pkg::DIR_OFF: nxt_st.rdata[7:0] = nxt_st.dir;
                cip_pkg::TRIS_OFF: nxt_st.rdata[7:0] = ~nxt_st.dir;
                cip_pkg::OUT_OFF: nxt_st.rdata[7:0] = nxt_st.outl;
                cip_pkg::CIN_OFF: nxt_st.rdata[7:0] = cin_st;
                cip_pkg::FOUT_OFF: nxt_st.rdata[7:0] = nxt_st.fout;
                cip_pkg::FIN_OFF: nxt_st.rdata[7:0] = fin_st;
                // only enabled digital pins read; no counting, levels only
                cip_pkg::SHARED_OFF: nxt_st.rdata[3:0] = sh_st & ~nxt_st.sh_adc;
                cip_pkg::FUNC_OFF: nxt_st.rdata[7:0] = nxt_st.func;
                cip_pkg::HWTRIS_OFF: nxt_st.rdata[7:0] = nxt_st.hw_tris;
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
            st_ff.dir <= cip_pkg::DIR_RST;
            st_ff.hw_tris <= ~cip_pkg::DIR_RST;
            st_ff.outl <= cip_pkg::OUT_RST;
            st_ff.fout <= cip_pkg::FOUT_RST;
            st_ff.func <= cip_pkg::FUNC_RST;
            st_ff.sh_adc <= 4'hF;
            st_ff.fan_adc <= cip_pkg::FAN_ADC_ON;
            st_ff.ready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout = st_ff.ready;
    assign hresp = st_ff.resp;
    assign hrdata = st_ff.rdata;
    assign cport_out = st_ff.pad_out;
    assign cport_oe = st_ff.pad_oe;
    assign fixed_output_port = st_ff.fout;
    assign shared_adc_en = st_ff.sh_adc;
    assign fixed_analogue_port_adc_en = st_ff.fan_adc;
    assign ir_rx = st_ff.spec[0];
    assign kbd_clk = st_ff.spec[1];
    assign kbd_data = st_ff.spec[2];
    assign i2c_scl = st_ff.spec[3];
    assign i2c_sda = st_ff.spec[4];

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic cmd_hi_wr;
    logic tris_wr;
    logic dir_src_wr;
    logic fout_wr;
    assign cmd_hi_wr = dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::CMD_OFF) && (cmd_op == cip_pkg::OP_HIGH);
    assign tris_wr = dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::TRIS_OFF);
    assign dir_src_wr = dp_wr && (reg_hit(st_ff.dp_addr, cip_pkg::DIR_OFF)
        || reg_hit(st_ff.dp_addr, cip_pkg::TRIS_OFF) || reg_hit(st_ff.dp_addr, cip_pkg::CMD_OFF));
    assign fout_wr = dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::FOUT_OFF);
    logic cmd_wr;
    logic out_wr;
    logic dir_wr;
    logic raw_wr;
    logic rd_req;
    assign cmd_wr = dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::CMD_OFF);
    assign out_wr = dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::OUT_OFF);
    assign dir_wr = dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::DIR_OFF);
    assign raw_wr = dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::HWTRIS_OFF);
    assign rd_req = addr_ok && !hwrite;

    dir_only_by_write_a: assert property (!$stable(st_ff.dir) |-> $past(dir_src_wr))
        else $error("direction changed without a direction write");
    pin_high_cmd_a: assert property (cmd_hi_wr |=> st_ff.dir[$past(cmd_pin)] && st_ff.outl[$past(cmd_pin)])
        else $error("pin high command did not make an output high");
    dir_readback_a: assert property (st_ff.dp_valid && !st_ff.dp_write
        && st_ff.dp_addr == cip_pkg::DIR_OFF |-> hrdata[7:0] == st_ff.dir && hrdata[31:8] == 24'h0)
        else $error("direction readback mismatch");
    tris_twin_a: assert property (tris_wr |=> st_ff.dir == ~$past(hwdata[7:0]) ##1 cport_oe[0] == st_ff.dir[0]
        || st_ff.dir != $past(st_ff.dir))
        else $error("inverted direction write not consistent");
    refresh_copy_a: assert property (refresh_tick |=> st_ff.hw_tris == ~st_ff.dir)
        else $error("tristate refresh did not restore direction");
    out_drive_a: assert property (cport_oe[7] |-> cport_out[7] == st_ff.outl[7])
        else $error("output pin not at latch level");
    fout_hold_a: assert property (!$stable(fixed_output_port) |-> $past(fout_wr))
        else $error("fixed output changed without a write");
    fan_analogue_a: assert property (fixed_analogue_port_adc_en == cip_pkg::FAN_ADC_ON)
        else $error("fixed analogue port left analogue mode");
    fin_read_a: assert property (addr_ok && !hwrite && haddr[7:0] == cip_pkg::FIN_OFF
        |=> hrdata[7:0] == $past(fin_st))
        else $error("standard input read wrong");
    cin_read_a: assert property (addr_ok && !hwrite && haddr[7:0] == cip_pkg::CIN_OFF
        |=> hrdata[7:0] == $past(cin_st))
        else $error("configurable port input read wrong");
    i2c_input_a: assert property (st_ff.func[cip_pkg::FUNC_I2C_BIT] |-> cport_oe[4:3] == 2'h0)
        else $error("i2c pins driven while i2c selected");
    ir_follow_a: assert property (ir_rx == $past(fin_st[0]) && kbd_data == $past(fin_st[7]))
        else $error("special input does not follow fixed input pin");
    shared_gate_a: assert property (addr_ok && !hwrite && haddr[7:0] == cip_pkg::SHARED_OFF
        && st_ff.sh_adc == 4'hF && !dp_wr |=> hrdata == 32'h0000_0000)
        else $error("analogue shared pins read as digital");
    oe_from_tris_a: assert property (cport_oe[7:5] == ~st_ff.hw_tris[7:5]
        && cport_oe[0] == ~st_ff.hw_tris[0])
        else $error("pad enable does not follow tristate");
    zero_wait_a: assert property (hreadyout && !hresp)
        else $error("slave inserted wait or error");

    // writes land at the end of their data phase, raw tristate only without a refresh; pins and enables follow their sources
    pin_low_cmd_a: assert property (cmd_wr && cmd_op == cip_pkg::OP_LOW
        |=> st_ff.dir[$past(cmd_pin)] && !st_ff.outl[$past(cmd_pin)])
        else $error("pin low command failed");
    pin_input_cmd_a: assert property (cmd_wr && cmd_op == cip_pkg::OP_INPUT
        |=> !st_ff.dir[$past(cmd_pin)])
        else $error("pin input command failed");
    dir_write_a: assert property (dir_wr |=> st_ff.dir == $past(hwdata[7:0]))
        else $error("direction write lost");
    out_write_a: assert property (out_wr |=> st_ff.outl == $past(hwdata[7:0]))
        else $error("output latch write lost");
    fout_write_a: assert property (fout_wr |=> fixed_output_port == $past(hwdata[7:0]))
        else $error("fixed output write lost");
    raw_tris_a: assert property (raw_wr && !refresh_tick |=> st_ff.hw_tris == $past(hwdata[7:0]))
        else $error("raw tristate write lost");
    pwm_drive_a: assert property (st_ff.func[cip_pkg::FUNC_PWM_BIT]
        |-> cport_oe[2:1] == 2'h3 && cport_out[2:1] == $past(pwm_level))
        else $error("pwm pins not driven");
    i2c_follow_a: assert property (i2c_scl == $past(cin_st[cip_pkg::SCL_BIT])
        && i2c_sda == $past(cin_st[cip_pkg::SDA_BIT]))
        else $error("i2c input does not follow pin");
    kbd_clk_follow_a: assert property (kbd_clk == $past(fin_st[cip_pkg::KCLK_BIT]))
        else $error("keyboard clock does not follow pin");
    shared_adc_a: assert property (shared_adc_en == ~st_ff.func[cip_pkg::FUNC_SHDIG_LSB +: 4])
        else $error("shared converter enable wrong");

    // readback comes from the very state it reports
    shared_level_a: assert property (rd_req && haddr[7:0] == cip_pkg::SHARED_OFF
        |=> hrdata[3:0] == ($past(sh_st) & ~st_ff.sh_adc) && hrdata[31:4] == 28'h0)
        else $error("shared read not gated level");
    tris_read_a: assert property (rd_req && haddr[7:0] == cip_pkg::TRIS_OFF
        |=> hrdata[7:0] == ~st_ff.dir && hrdata[31:8] == 24'h0)
        else $error("inverted direction read wrong");
    out_read_a: assert property (rd_req && haddr[7:0] == cip_pkg::OUT_OFF
        |=> hrdata == 32'(st_ff.outl))
        else $error("output latch read wrong");
    rdata_idle_a: assert property (!(st_ff.dp_valid && !st_ff.dp_write) |-> hrdata == 32'h0000_0000)
        else $error("read data outside read phase");

    pin_high_c: cover property (cmd_hi_wr);
    tris_write_c: cover property (tris_wr);
    raw_overwrite_c: cover property (dp_wr && reg_hit(st_ff.dp_addr, cip_pkg::HWTRIS_OFF) ##[1:60] refresh_tick);
    shared_read_c: cover property (st_ff.dp_valid && !st_ff.dp_write && st_ff.dp_addr == cip_pkg::SHARED_OFF
        && hrdata[3:0] != 4'h0);
    pwm_drive_c: cover property (st_ff.func[cip_pkg::FUNC_PWM_BIT]);
endmodule : cip_port_set

// [cip_pin_world.sv]
// switches, sensors and loads standing at the pins of the port set
// assumes every switch is a static level set by the bench between frames of checks
`timescale 1ns/1ps
module cip_pin_world (
    input wire logic [7:0] cport_out,
    input wire logic [7:0] cport_oe,
    input wire logic [7:0] sw_cport,
    input wire logic [7:0] sw_fixed,
    input wire logic [3:0] sw_shared,
    output logic [7:0] cport_in,
    output logic [7:0] fixed_input_port,
    output logic [3:0] shared_in
);
    // a driven pin wins over the weak switch, an undriven pin shows the switch
    assign cport_in = (cport_oe & cport_out) | (~cport_oe & sw_cport);
    assign fixed_input_port = sw_fixed;
    assign shared_in = sw_shared;
endmodule : cip_pin_world

// [test_configurable_io_port_set.sv]
// self-checking bench for the configurable i/o port set over ahb-lite
// assumes cip_port_set, cip_pkg and the pin world model are compiled first
`timescale 1ns/1ps
module test_configurable_io_port_set;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans, pwm_level;
    logic [2:0] hsize, fan_en;
    logic [7:0] cport_in, cport_out, cport_oe, fin, fout, sw_cport, sw_fixed;
    logic [3:0] shared_in, shared_adc_en, sw_shared;
    logic ir_rx, kbd_clk, kbd_data, i2c_scl, i2c_sda;
    int num_errors = 0;
    int total_checks = 0;
    logic [1:0] ops [4] = '{cip_pkg::OP_HIGH, cip_pkg::OP_LOW, cip_pkg::OP_OUTPUT, cip_pkg::OP_INPUT};
    logic [2:0] pins [4] = '{3'h3, 3'h5, 3'h0, 3'h3};
    logic [7:0] dirs [4] = '{8'h08, 8'h28, 8'h29, 8'h21};

    cip_port_set cip_port_set_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cport_in(cport_in),
        .cport_out(cport_out), .cport_oe(cport_oe), .pwm_level(pwm_level), .fixed_input_port(fin),
        .fixed_output_port(fout), .shared_in(shared_in), .shared_adc_en(shared_adc_en),
        .fixed_analogue_port_adc_en(fan_en), .ir_rx(ir_rx), .kbd_clk(kbd_clk), .kbd_data(kbd_data),
        .i2c_scl(i2c_scl), .i2c_sda(i2c_sda));
    cip_pin_world cip_pin_world_i (.cport_out(cport_out), .cport_oe(cport_oe), .sw_cport(sw_cport),
        .sw_fixed(sw_fixed), .sw_shared(sw_shared), .cport_in(cport_in), .fixed_input_port(fin),
        .shared_in(shared_in));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // hready is sampled at each edge; the wait ends when it is high, or fails the bench after 20 edges
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            results();
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, off};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
        #1;
    endtask : bus

    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        bus(1'b1, off, d);
    endtask : wr

    task automatic rd(input logic [7:0] off, input logic [31:0] exp);
        bus(1'b0, off, 32'h00000000);
        chk(rdv, exp);
    endtask : rd

    // lets a pin change pass the three-stage synchroniser
    task automatic settle;
        repeat (8) @(posedge hclk);
        #1;
    endtask : settle

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        pwm_level = 2'h2;
        sw_cport = 8'h5A;
        sw_fixed = 8'hC1;
        sw_shared = 4'h9;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk(32'(cport_oe), 32'h00000000);
        chk(32'(fout), 32'h00000000);
        chk(32'(shared_adc_en), 32'h0000000F);
        chk(32'(fan_en), 32'h00000007);
        chk(32'({hreadyout, hresp}), 32'h00000002);
        rd(cip_pkg::DIR_OFF, 32'h00000000);
        rd(cip_pkg::TRIS_OFF, 32'h000000FF);
        rd(8'h30, 32'h00000000);
        $display("test reset done");
        wr(cip_pkg::DIR_OFF, 32'h000000FF);
        chk(32'(cport_oe), 32'h000000FF);
        rd(cip_pkg::TRIS_OFF, 32'h00000000);
        wr(cip_pkg::TRIS_OFF, 32'h0000000F);
        rd(cip_pkg::DIR_OFF, 32'h000000F0);
        chk(32'(cport_oe), 32'h000000F0);
        $display("test direction done");
        wr(cip_pkg::OUT_OFF, 32'h000000FF);
        chk(32'(cport_out & cport_oe), 32'h000000F0);
        settle();
        rd(cip_pkg::CIN_OFF, 32'h000000FA);
        wr(cip_pkg::OUT_OFF, 32'h00000000);
        settle();
        rd(cip_pkg::CIN_OFF, 32'h0000000A);
        chk(32'(fout), 32'h00000000);
        $display("test output done");
        wr(cip_pkg::DIR_OFF, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            wr(cip_pkg::CMD_OFF, {22'h000000, ops[i], 5'h00, pins[i]});
            rd(cip_pkg::DIR_OFF, 32'(dirs[i]));
            chk(32'(cport_oe), 32'(dirs[i]));
            if (i < 2) begin
                chk(32'(cport_out[pins[i]]), 32'(ops[i] == cip_pkg::OP_HIGH));
            end
        end
        $display("test commands done");
        wr(cip_pkg::DIR_OFF, 32'h00000000);
        wr(cip_pkg::HWTRIS_OFF, 32'h00000000);
        chk(32'(cport_oe), 32'h000000FF);
        repeat (cip_pkg::REFRESH_CYC + 10) @(posedge hclk);
        #1;
        chk(32'(cport_oe), 32'h00000000);
        rd(cip_pkg::HWTRIS_OFF, 32'h000000FF);
        $display("test refresh done");
        wr(cip_pkg::FOUT_OFF, 32'h000000A5);
        chk(32'(fout), 32'h000000A5);
        rd(cip_pkg::FOUT_OFF, 32'h000000A5);
        rd(cip_pkg::FIN_OFF, 32'h000000C1);
        chk(32'({ir_rx, kbd_clk, kbd_data}), 32'h00000007);
        sw_fixed <= 8'h3E;
        settle();
        rd(cip_pkg::FIN_OFF, 32'h0000003E);
        chk(32'({ir_rx, kbd_clk, kbd_data}), 32'h00000000);
        rd(cip_pkg::CIN_OFF, 32'h0000005A);
        $display("test fixed ports done");
        rd(cip_pkg::SHARED_OFF, 32'h00000000);
        wr(cip_pkg::FUNC_OFF, 32'h000000F0);
        chk(32'(shared_adc_en), 32'h00000000);
        rd(cip_pkg::SHARED_OFF, 32'h00000009);
        chk(32'(fan_en), 32'h00000007);
        $display("test shared done");
        wr(cip_pkg::FUNC_OFF, 32'h00000001);
        chk(32'(cport_oe[2:1]), 32'h00000003);
        chk(32'(cport_out[2:1]), 32'(pwm_level));
        @(posedge hclk);
        pwm_level <= 2'h1;
        @(posedge hclk);
        #1;
        chk(32'(cport_out[2:1]), 32'h00000001);
        wr(cip_pkg::DIR_OFF, 32'h000000FF);
        wr(cip_pkg::FUNC_OFF, 32'h00000002);
        chk(32'(cport_oe[4:3]), 32'h00000000);
        settle();
        chk(32'({i2c_scl, i2c_sda}), 32'h00000003);
        sw_cport <= 8'h42;
        settle();
        chk(32'({i2c_scl, i2c_sda}), 32'h00000000);
        $display("test special functions done");
        results();
    end
endmodule : test_configurable_io_port_set
